//--- msc_pkg.sv
// Package with modes, timing constants and carriers for the mode/strap block
package msc_pkg;
	typedef enum logic [2:0] {
		MSC_INIT,
		MSC_NORMAL,
		MSC_STOP,
		MSC_SLEEP,
		MSC_RESTART,
		MSC_FAILSAFE
	} msc_mode_t;

	localparam int MSC_CLK_MHZ         = 50;
	localparam int MSC_TEST_FILT_NS    = 1000;
	localparam int MSC_CFG_FILT_NS     = 1000;
	localparam int MSC_RST_DELAY_US    = 10;
	localparam int MSC_RESTART_US      = 2;
	localparam int MSC_TEST_FILT_CYC   = (MSC_TEST_FILT_NS * MSC_CLK_MHZ + 999) / 1000;
	localparam int MSC_CFG_FILT_CYC    = (MSC_CFG_FILT_NS * MSC_CLK_MHZ + 999) / 1000;
	localparam int MSC_RST_DELAY_CYC   = MSC_RST_DELAY_US * MSC_CLK_MHZ;
	localparam int MSC_RESTART_CYC     = MSC_RESTART_US * MSC_CLK_MHZ;
	localparam int MSC_CNT_W           = 16;

	localparam logic [31:0] MSC_FRAME_CRC_ON  = 32'h67aaaa0e;
	localparam logic [31:0] MSC_FRAME_CRC_OFF = 32'he7aaaac3;
	localparam logic [1:0]  MSC_CMD_NONE      = 2'h0;

	// Mode and other requests arriving with an SPI command
	typedef enum logic [2:0] {
		MSC_REQ_NONE,
		MSC_REQ_NORMAL,
		MSC_REQ_STOP,
		MSC_REQ_SLEEP,
		MSC_REQ_SOFT_RESET,
		MSC_REQ_WD_REFRESH,
		MSC_REQ_STATUS,
		MSC_REQ_OTHER_WRITE
	} msc_req_t;

	typedef struct packed {
		logic        valid;
		msc_req_t    req;
		logic [31:0] frame;
	} msc_spi_cmd_t;

	typedef struct packed {
		logic wake;
		logic wd_fail;
		logic uv_fail;
		logic therm_fail;
	} msc_events_t;
endpackage : msc_pkg

//--- msc_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module msc_sync
	import msc_pkg::*;
#(
	parameter logic RESET_VAL = 1'b1
)
(
	// Clocking
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	// Data
	input  wire logic din,
	output logic      dout
);
	logic meta_reg;
	logic meta_next;
	logic dout_reg;
	logic dout_next;

	always_comb
	begin
		meta_next = ce ? din : meta_reg;
		dout_next = ce ? meta_reg : dout_reg;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			meta_reg <= RESET_VAL;
			dout_reg <= RESET_VAL;
		end
		else
		begin
			meta_reg <= meta_next;
			dout_reg <= dout_next;
		end
	end

	assign dout = dout_reg;
endmodule : msc_sync

//--- msc_filter.sv
// Continuous digital filter: output follows input only after a stable run
`timescale 1ns/100ps
module msc_filter
	import msc_pkg::*;
#(
	parameter int FILT_CYC = MSC_TEST_FILT_CYC
)
(
	// Clocking
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	// Control
	input  wire logic preset,
	input  wire logic din,
	output logic      dout
);
	logic [MSC_CNT_W-1:0] cnt_reg;
	logic [MSC_CNT_W-1:0] cnt_next;
	logic                 out_reg;
	logic                 out_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		out_next = out_reg;
		if (ce)
		begin
			if (preset)
			begin
				cnt_next = '0;
				out_next = 1'b1;
			end
			else if (din == out_reg)
				cnt_next = '0;
			else if (cnt_reg >= MSC_CNT_W'(FILT_CYC - 1))
			begin
				cnt_next = '0;
				out_next = din;
			end
			else
				cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cnt_reg <= '0;
			out_reg <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule : msc_filter

//--- msc_mode_ctrl.sv
// Operating-mode state machine with development-mode and CRC strap latching
// Summary of operation
// - Six modes: init, normal, stop, sleep, restart, fail-safe.
// - Power-up and soft reset both enter init mode.
// - Stop mode keeps the main regulator on.
// - Sleep mode turns the main regulator off.
// - Wake from sleep/fail-safe or failures pass through restart, asserting reset.
// - Critical failures such as thermal shutdown enter fail-safe mode; here only from init, normal and stop, not from sleep or restart.
// - Development mode: all modes, watchdog runs, watchdog faults go to interrupt.
// - Watchdog reset signalling can be re-enabled in development mode.
// - Watchdog always starts with its long open window.
// - All configuration travels over a 32-bit SPI, device as slave.
// - Test pin weakly pulled high after reset output release.
// - Development mode only in power-up init, regulator good, reset high.
// - Low test pin plus any SPI command latches development mode.
// - Test pin filtered; filtered level starts at one on reset release.
// - Mode change without SPI command during monitoring cancels development mode.
// - Pulled-down PWM strap enables CRC; open strap disables it.
// - CRC strap taken in power-up init or restart, regulator good, reset low.
// - Strap filtered during reset delay, latched on reset output rising edge.
// - Frame 67aaaa0e enables CRC unconditionally.
// - Frame e7aaaac3 disables CRC unconditionally.
// - Fixed functions keep settings programmed in normal or init mode.
// - Stop mode ignores writes with error flag, except allowed commands; here CRC on/off frames still take effect in stop mode.
`timescale 1ns/100ps
module msc_mode_ctrl
	import msc_pkg::*;
#(
	parameter int RST_DELAY_CYC = MSC_RST_DELAY_CYC,
	parameter int RESTART_CYC   = MSC_RESTART_CYC
)
(
	// Clocking
	input  wire logic   mclk,
	input  wire logic   rst,
	input  wire logic   ce,
	// Supply status
	input  wire logic   main_regulator_good,
	input  wire logic   power_on_flag,
	// Strap and test pins
	input  wire logic   interrupt_test_pin_in,
	output logic        interrupt_test_pin_out,
	output logic        interrupt_test_pin_oe,
	output logic        interrupt_test_pullup_en,
	input  wire logic   pwm_check_strap_pin,
	// Decoded SPI commands
	input  wire msc_spi_cmd_t spi_cmd,
	// Events
	input  wire msc_events_t  events,
	input  wire logic   wd_reset_reenable,
	// Status and outputs
	output msc_mode_t   mode,
	output logic        reset_out_n,
	output logic        main_regulator_en,
	output logic        dev_mode,
	output logic        crc_enable,
	output logic        filtered_test_level,
	output logic        wd_long_window,
	output logic        wd_irq,
	output logic        settings_fixed,
	output logic        spi_error_flag
);
	logic test_sync;
	logic strap_sync;
	logic strap_filt;

	msc_mode_t            mode_reg, mode_next;
	logic [MSC_CNT_W-1:0] dly_reg, dly_next;
	logic                 rsto_reg, rsto_next;
	logic                 from_por_reg, from_por_next;
	logic                 dev_reg, dev_next;
	logic                 mon_reg, mon_next;
	logic                 crc_reg, crc_next;
	logic                 wdrst_reg, wdrst_next;
	logic                 wdlw_reg, wdlw_next;
	logic                 irq_reg, irq_next;
	logic                 err_reg, err_next;
	logic                 rise;
	logic                 cmd;
	logic                 allowed;

	msc_sync #(.RESET_VAL(1'b1)) u_sync_test
	(
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.din  (interrupt_test_pin_in),
		.dout (test_sync)
	);

	msc_sync #(.RESET_VAL(1'b1)) u_sync_strap
	(
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.din  (pwm_check_strap_pin),
		.dout (strap_sync)
	);

	msc_filter #(.FILT_CYC(MSC_TEST_FILT_CYC)) u_filt_test
	(
		.mclk   (mclk),
		.rst    (rst),
		.ce     (ce),
		.preset (rise),
		.din    (test_sync),
		.dout   (filtered_test_level)
	);

	msc_filter #(.FILT_CYC(MSC_CFG_FILT_CYC)) u_filt_strap
	(
		.mclk   (mclk),
		.rst    (rst),
		.ce     (ce),
		.preset (1'b0),
		.din    (strap_sync),
		.dout   (strap_filt)
	);

	assign rise    = ce && !rsto_reg && rsto_next;
	assign cmd     = spi_cmd.valid;
	assign allowed = spi_cmd.req inside {MSC_REQ_NORMAL, MSC_REQ_SOFT_RESET,
		MSC_REQ_WD_REFRESH, MSC_REQ_STATUS};

	always_comb
	begin
		mode_next     = mode_reg;
		dly_next      = dly_reg;
		rsto_next     = rsto_reg;
		from_por_next = from_por_reg;
		dev_next      = dev_reg;
		mon_next      = mon_reg;
		crc_next      = crc_reg;
		wdrst_next    = wdrst_reg;
		wdlw_next     = wdlw_reg;
		irq_next      = irq_reg;
		err_next      = err_reg;
		if (ce)
		begin
			irq_next = 1'b0;
			err_next = 1'b0;
			if (!rsto_reg && dly_reg != '0)
				dly_next = dly_reg - 1'b1;
			if (!rsto_reg && dly_reg == '0 && power_on_flag && main_regulator_good)
				rsto_next = 1'b1;
			if (!main_regulator_good)
				rsto_next = 1'b0;
			case (mode_reg)
				MSC_INIT, MSC_NORMAL, MSC_STOP:
				begin
					if (events.therm_fail)
						mode_next = MSC_FAILSAFE;
					else if (events.uv_fail || (events.wd_fail && wdrst_reg))
						mode_next = MSC_RESTART;
					else if (cmd && spi_cmd.req == MSC_REQ_SOFT_RESET)
					begin
						mode_next = MSC_INIT;
						from_por_next = 1'b0;
						wdlw_next = 1'b1;
					end
					else if (cmd && mode_reg == MSC_STOP && !allowed)
						err_next = 1'b1;
					else if (cmd && spi_cmd.req == MSC_REQ_NORMAL)
						mode_next = MSC_NORMAL;
					else if (cmd && mode_reg == MSC_NORMAL
						&& spi_cmd.req == MSC_REQ_STOP)
						mode_next = MSC_STOP;
					else if (cmd && mode_reg == MSC_NORMAL
						&& spi_cmd.req == MSC_REQ_SLEEP)
						mode_next = MSC_SLEEP;
					if (events.wd_fail && !wdrst_reg)
						irq_next = 1'b1;
					if (cmd && spi_cmd.req == MSC_REQ_WD_REFRESH)
						wdlw_next = 1'b0;
				end
				MSC_SLEEP, MSC_FAILSAFE:
				begin
					if (events.wake && !events.therm_fail)
						mode_next = MSC_RESTART;
				end
				MSC_RESTART:
				begin
					if (dly_reg == '0 && rsto_reg)
						mode_next = MSC_NORMAL;
				end
				default:
					mode_next = MSC_INIT;
			endcase
			if (mode_next == MSC_RESTART && mode_reg != MSC_RESTART)
			begin
				rsto_next = 1'b0;
				dly_next  = MSC_CNT_W'(RESTART_CYC);
				wdlw_next = 1'b1;
			end
			// CRC strap window, filtered value taken at release
			if (rise && (mode_reg == MSC_RESTART || (mode_reg == MSC_INIT
				&& from_por_reg)) && power_on_flag && main_regulator_good)
				crc_next = !strap_filt;
			if (cmd && spi_cmd.frame == MSC_FRAME_CRC_ON)
				crc_next = 1'b1;
			else if (cmd && spi_cmd.frame == MSC_FRAME_CRC_OFF)
				crc_next = 1'b0;
			// Development mode monitoring
			if (rise && mode_reg == MSC_INIT && from_por_reg)
				mon_next = 1'b1;
			if (mon_reg)
			begin
				if (mode_next != mode_reg && !cmd)
				begin
					mon_next = 1'b0;
					dev_next = 1'b0;
				end
				else if (cmd && rsto_reg && power_on_flag && main_regulator_good)
				begin
					mon_next = 1'b0;
					dev_next = !filtered_test_level;
					wdrst_next = filtered_test_level;
				end
			end
			if (dev_reg && wd_reset_reenable)
				wdrst_next = 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mode_reg     <= MSC_INIT;
			dly_reg      <= MSC_CNT_W'(RST_DELAY_CYC);
			rsto_reg     <= 1'b0;
			from_por_reg <= 1'b1;
			dev_reg      <= 1'b0;
			mon_reg      <= 1'b0;
			crc_reg      <= 1'b0;
			wdrst_reg    <= 1'b1;
			wdlw_reg     <= 1'b1;
			irq_reg      <= 1'b0;
			err_reg      <= 1'b0;
		end
		else
		begin
			mode_reg     <= mode_next;
			dly_reg      <= dly_next;
			rsto_reg     <= rsto_next;
			from_por_reg <= from_por_next;
			dev_reg      <= dev_next;
			mon_reg      <= mon_next;
			crc_reg      <= crc_next;
			wdrst_reg    <= wdrst_next;
			wdlw_reg     <= wdlw_next;
			irq_reg      <= irq_next;
			err_reg      <= err_next;
		end
	end

	assign mode                     = mode_reg;
	assign reset_out_n              = rsto_reg;
	assign main_regulator_en        = mode_reg != MSC_SLEEP;
	assign dev_mode                 = dev_reg;
	assign crc_enable               = crc_reg;
	assign wd_long_window           = wdlw_reg;
	assign wd_irq                   = irq_reg;
	assign settings_fixed           = mode_reg inside {MSC_STOP, MSC_SLEEP};
	assign spi_error_flag           = err_reg;
	assign interrupt_test_pullup_en = rsto_reg;
	assign interrupt_test_pin_out   = 1'b0;
	assign interrupt_test_pin_oe    = 1'b0;

	a_sleep_reg_off: assert property (@(posedge mclk) disable iff (rst)
		(mode == MSC_SLEEP) |-> !main_regulator_en)
		else $error("regulator on in sleep");
	a_stop_reg_on: assert property (@(posedge mclk) disable iff (rst)
		(mode == MSC_STOP) |-> main_regulator_en)
		else $error("regulator off in stop");
	a_restart_rst_low: assert property (@(posedge mclk) disable iff (rst)
		(ce && mode != MSC_RESTART && mode_next == MSC_RESTART)
		|=> !reset_out_n)
		else $error("restart without reset");
	a_therm_failsafe: assert property (@(posedge mclk) disable iff (rst)
		(ce && events.therm_fail && mode inside {MSC_NORMAL, MSC_STOP})
		|=> mode == MSC_FAILSAFE)
		else $error("thermal did not enter fail-safe");
	a_crc_on_frame: assert property (@(posedge mclk) disable iff (rst)
		(ce && spi_cmd.valid && spi_cmd.frame == MSC_FRAME_CRC_ON)
		|=> crc_enable)
		else $error("crc not enabled by frame");
	a_crc_off_frame: assert property (@(posedge mclk) disable iff (rst)
		(ce && spi_cmd.valid && spi_cmd.frame == MSC_FRAME_CRC_OFF)
		|=> !crc_enable)
		else $error("crc not disabled by frame");
	a_stop_write_err: assert property (@(posedge mclk) disable iff (rst)
		(ce && mode == MSC_STOP && spi_cmd.valid
		&& spi_cmd.req == MSC_REQ_OTHER_WRITE && !events.therm_fail
		&& !events.uv_fail && !(events.wd_fail && wdrst_reg))
		|=> spi_error_flag && mode == MSC_STOP)
		else $error("stop write not flagged");
	a_filt_start_one: assert property (@(posedge mclk) disable iff (rst)
		rise |=> filtered_test_level)
		else $error("filtered level not one at release");
	a_softrst_init: assert property (@(posedge mclk) disable iff (rst)
		(ce && mode == MSC_NORMAL && spi_cmd.valid
		&& spi_cmd.req == MSC_REQ_SOFT_RESET && !events.therm_fail
		&& !events.uv_fail && !(events.wd_fail && wdrst_reg))
		|=> mode == MSC_INIT && wd_long_window)
		else $error("soft reset not to init");
endmodule : msc_mode_ctrl

//--- msc_host_model.sv
// Host microcontroller model: SPI command source and board straps
`timescale 1ns/100ps
module msc_host_model
	import msc_pkg::*;
(
	// Clocking
	input  wire logic    mclk,
	// Host side
	output msc_spi_cmd_t spi_cmd,
	output logic         test_pd,
	output logic         strap_pd
);
	initial
	begin
		spi_cmd  = '0;
		test_pd  = 1'b0;
		strap_pd = 1'b1;
	end

	// Whole 32-bit frame for one cycle, then the bus shows other data
	task automatic send(input msc_req_t r, input logic [31:0] f);
		@(negedge mclk);
		spi_cmd = '{1'b1, r, f};
		@(negedge mclk);
		spi_cmd = '{1'b0, MSC_REQ_NONE, ~f};
	endtask : send

	// External pull-downs fitted on the test and strap pins
	task automatic pins(input logic tp, input logic sp);
		test_pd  = tp;
		strap_pd = sp;
	endtask : pins
endmodule : msc_host_model

//--- mode_and_strap_config_bench.sv
// Self-checking bench for the mode and strap configuration block
`timescale 1ns/100ps
module mode_and_strap_config_bench
	import msc_pkg::*;
;
	logic         mclk = 1'b0;
	logic         rst = 1'b1;
	logic         wd_re_in = 1'b0;
	logic         ce = 1'b1;
	logic         supply_ok = 1'b1;
	msc_events_t  events = '0;
	msc_spi_cmd_t spi_cmd;
	msc_mode_t    mode, exp_mode;
	logic         tp_out, tp_oe, pull_en, test_pd, strap_pd, rout_n;
	logic         reg_en, dev, crc, filt, wd_long, irq, fixed, err;
	logic         exp_crc, exp_dev, wd_re;
	logic  [31:0] seed = 32'ha029;
	int           failures = 0;
	int           check_count = 0;
	int           cycles = 0;
	wire logic    test_pin = tp_oe ? tp_out : !test_pd;

	always #10 mclk = ~mclk;

	msc_host_model i_msc_host_model (.mclk(mclk), .spi_cmd(spi_cmd),
		.test_pd(test_pd), .strap_pd(strap_pd));

	// Reset delay outlasts strap sync and filter so the strap settles first
	msc_mode_ctrl #(.RST_DELAY_CYC(80), .RESTART_CYC(10)) i_msc_mode_ctrl (
		.mclk(mclk), .rst(rst), .ce(ce), .main_regulator_good(supply_ok),
		.power_on_flag(supply_ok), .interrupt_test_pin_in(test_pin),
		.interrupt_test_pin_out(tp_out), .interrupt_test_pin_oe(tp_oe),
		.interrupt_test_pullup_en(pull_en),
		.pwm_check_strap_pin(!strap_pd),
		.spi_cmd(spi_cmd), .events(events), .wd_reset_reenable(wd_re_in),
		.mode(mode), .reset_out_n(rout_n), .main_regulator_en(reg_en),
		.dev_mode(dev), .crc_enable(crc), .filtered_test_level(filt),
		.wd_long_window(wd_long), .wd_irq(irq), .settings_fixed(fixed),
		.spi_error_flag(err));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			end_of_test();
		end
	end

	task automatic chk_bit(input string n, input logic e, input logic g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit

	task automatic chk_mode(input msc_mode_t e, input msc_mode_t g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected mode expected %0d seen %0d", e, g);
		end
	endtask : chk_mode

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic check_all(input logic e_err, input logic e_irq);
		chk_mode(exp_mode, mode);
		chk_bit("crc_enable", exp_crc, crc);
		chk_bit("dev_mode", exp_dev, dev);
		chk_bit("main_regulator_en", exp_mode != MSC_SLEEP, reg_en);
		chk_bit("settings_fixed", exp_mode inside {MSC_STOP, MSC_SLEEP},
			fixed);
		chk_bit("spi_error_flag", e_err, err);
		chk_bit("wd_irq", e_irq, irq);
	endtask : check_all

	task automatic cmd(input msc_req_t r, input logic [31:0] f);
		logic e;
		e = exp_mode == MSC_STOP &&
			r inside {MSC_REQ_STOP, MSC_REQ_SLEEP, MSC_REQ_OTHER_WRITE};
		i_msc_host_model.send(r, f);
		if (!e)
			case (r)
				MSC_REQ_NORMAL:     exp_mode = MSC_NORMAL;
				MSC_REQ_STOP:       exp_mode = MSC_STOP;
				MSC_REQ_SLEEP:      exp_mode = MSC_SLEEP;
				MSC_REQ_SOFT_RESET: exp_mode = MSC_INIT;
				default:            ;
			endcase
		if (f === MSC_FRAME_CRC_ON)
			exp_crc = 1'b1;
		if (f === MSC_FRAME_CRC_OFF)
			exp_crc = 1'b0;
		check_all(e, 1'b0);
	endtask : cmd

	task automatic ev(input msc_events_t v);
		logic e_irq;
		int   n;
		e_irq = v.wd_fail && exp_dev && !wd_re;
		@(negedge mclk);
		events = v;
		@(negedge mclk);
		events = '0;
		if (v.therm_fail)
			exp_mode = MSC_FAILSAFE;
		else if ((v.wake && exp_mode inside {MSC_SLEEP, MSC_FAILSAFE}) ||
			(v.wd_fail && !e_irq))
			exp_mode = MSC_RESTART;
		check_all(1'b0, e_irq);
		if (exp_mode == MSC_RESTART)
		begin
			chk_bit("reset_out_n", 1'b0, rout_n);
			for (n = 0; n < 300 && mode !== MSC_NORMAL; n++)
				@(negedge mclk);
			exp_mode = MSC_NORMAL;
			exp_crc  = 1'b1;
			check_all(1'b0, 1'b0);
			chk_bit("reset_out_n", 1'b1, rout_n);
		end
	endtask : ev

	initial
	begin
		exp_mode = MSC_INIT;
		exp_crc  = 1'b0;
		exp_dev  = 1'b0;
		wd_re    = 1'b0;
		repeat (20) @(negedge mclk);
		check_all(1'b0, 1'b0);
		chk_bit("reset_out_n", 1'b0, rout_n);
		chk_bit("wd_long_window", 1'b1, wd_long);
		chk_bit("pullup_en", 1'b0, pull_en);
		rst = 1'b0;
		for (int n = 0; n < 120 && rout_n !== 1'b1; n++)
			@(negedge mclk);
		exp_crc = 1'b1;
		check_all(1'b0, 1'b0);
		chk_bit("filtered_test_level", 1'b1, filt);
		chk_bit("pullup_en", 1'b1, pull_en);
		chk_bit("wd_long_window", 1'b1, wd_long);
		$display("test power_up done");
		i_msc_host_model.pins(1'b1, 1'b1);
		repeat (60) @(negedge mclk);
		chk_bit("filtered_test_level", 1'b0, filt);
		chk_bit("test_pin_oe", 1'b0, tp_oe);
		chk_bit("test_pin_out", 1'b0, tp_out);
		exp_dev = 1'b1;
		cmd(MSC_REQ_STATUS, 32'h0);
		i_msc_host_model.pins(1'b0, 1'b1);
		cmd(MSC_REQ_NORMAL, 32'h0);
		$display("test development_mode done");
		for (int k = 0; k < 8; k++)
		begin
			seed = xs(seed);
			cmd(MSC_REQ_OTHER_WRITE, seed ^ 32'h1);
		end
		cmd(MSC_REQ_OTHER_WRITE, MSC_FRAME_CRC_OFF);
		cmd(MSC_REQ_OTHER_WRITE, MSC_FRAME_CRC_ON);
		cmd(MSC_REQ_OTHER_WRITE, MSC_FRAME_CRC_OFF);
		$display("test recovery_frames done");
		cmd(MSC_REQ_STOP, 32'h0);
		cmd(MSC_REQ_OTHER_WRITE, 32'h0);
		cmd(MSC_REQ_SLEEP, 32'h0);
		cmd(MSC_REQ_STOP, 32'h0);
		cmd(MSC_REQ_WD_REFRESH, 32'h0);
		cmd(MSC_REQ_STATUS, 32'h0);
		cmd(MSC_REQ_NORMAL, 32'h0);
		$display("test stop_mode done");
		ev('{1'b0, 1'b1, 1'b0, 1'b0});
		cmd(MSC_REQ_SLEEP, 32'h0);
		ev('{1'b1, 1'b0, 1'b0, 1'b0});
		ev('{1'b0, 1'b0, 1'b0, 1'b1});
		ev('{1'b1, 1'b0, 1'b0, 1'b0});
		@(negedge mclk);
		wd_re_in = 1'b1;
		@(negedge mclk);
		wd_re_in = 1'b0;
		wd_re = 1'b1;
		ev('{1'b0, 1'b1, 1'b0, 1'b0});
		$display("test events done");
		// A command seen while the clock enable is low must change nothing
		ce = 1'b0;
		i_msc_host_model.send(MSC_REQ_SLEEP, 32'h0);
		ce = 1'b1;
		check_all(1'b0, 1'b0);
		$display("test clock_enable done");
		cmd(MSC_REQ_SOFT_RESET, 32'h0);
		$display("test soft_reset done");
		// Second reset: supply held off, then a mode change cancels monitoring
		rst       = 1'b1;
		supply_ok = 1'b0;
		repeat (20) @(negedge mclk);
		exp_mode = MSC_INIT;
		exp_crc  = 1'b0;
		exp_dev  = 1'b0;
		wd_re    = 1'b0;
		rst      = 1'b0;
		repeat (100) @(negedge mclk);
		check_all(1'b0, 1'b0);
		chk_bit("reset_out_n", 1'b0, rout_n);
		supply_ok = 1'b1;
		i_msc_host_model.pins(1'b1, 1'b1);
		for (int n = 0; n < 20 && rout_n !== 1'b1; n++)
			@(negedge mclk);
		exp_crc = 1'b1;
		check_all(1'b0, 1'b0);
		repeat (60) @(negedge mclk);
		ev('{1'b0, 1'b0, 1'b0, 1'b1});
		cmd(MSC_REQ_STATUS, 32'h0);
		$display("test monitor_cancel done");
		end_of_test();
	end
endmodule : mode_and_strap_config_bench
